// [include/cache_sram_pkg.sv]
/*
 * constants for the synchronous 16K x 16 cache memory.
 * assumes a single system clock shared with processor and cache controller.
 */
package cache_sram_pkg;
	localparam int ADDR_W     = 14;
	localparam int DATA_W     = 16;
	localparam int DEPTH      = 16384;
	localparam int LO_BYTE_LSB = 0;
	localparam int HI_BYTE_LSB = 8;
	localparam int BYTE_W     = 8;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [13:0] ADDR_RESET = 14'h0000;
endpackage

// [include/sram_write_if.sv]
/*
 * write request carrier between the pin front end and the storage array.
 * assumes both ends sit on clk_sys.
 */
`timescale 1ns/10ps
interface sram_write_if;
	logic        loWrite;
	logic        hiWrite;
	logic [13:0] addr;
	logic [15:0] data;
	modport source (output loWrite, output hiWrite, output addr, output data);
	modport sink   (input loWrite, input hiWrite, input addr, input data);
endinterface

// [hw/sram_array.sv]
/*
 * storage array of 16K words with independent byte lanes and a registered read port.
 * assumes write requests arrive already qualified on the falling clock edge.
 */
`timescale 1ns/10ps
module sram_array (
	input  wire logic        clk_sys,
	input  wire logic [13:0] readAddr,
	output logic      [15:0] readData,
	sram_write_if.sink       wr
);
	logic [15:0] mem [0:cache_sram_pkg::DEPTH-1];

	// byte lanes written independently; no reset on the array, like a real ram
	always_ff @(negedge clk_sys) begin
		if (wr.loWrite) begin
			mem[wr.addr][7:0] <= wr.data[7:0];
		end
		if (wr.hiWrite) begin
			mem[wr.addr][15:8] <= wr.data[15:8];
		end
	end

	// read of readAddr as presented (the top feeds it addr, not addrReg), sampled on the rising edge
	always_ff @(posedge clk_sys) begin
		readData <= mem[readAddr];
	end
endmodule // sram_array

// [hw/sync_cache_sram.sv]
/*
 * synchronous 16K x 16 cache memory: registered address, self-timed byte write,
 * output-drive enable for shared data pins.
 * assumes processor and cache controller drive all inputs on clk_sys.
 */
`timescale 1ns/10ps
module sync_cache_sram (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [13:0] addr,
	input  wire logic        low_byte_write_strobe_n,
	input  wire logic        high_byte_write_strobe_n,
	input  wire logic        outputDrive_n,
	input  wire logic [15:0] dataIn,
	output logic      [15:0] dataOut,
	output logic             dataOutEnable_n
);
	logic [13:0] addrReg;
	logic [15:0] dataLatch;
	logic [15:0] arrayData;
	logic        next_driveOff;
	sram_write_if wrBus ();

	// address register on the rising edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			addrReg <= cache_sram_pkg::ADDR_RESET;
		end else begin
			addrReg <= addr;
		end
	end

	// data-in latch captured at the rising edge, so it lines up with the address
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dataLatch <= cache_sram_pkg::DATA_RESET;
		end else begin
			dataLatch <= dataIn;
		end
	end

	// write qualification: strobes sampled by the array on the falling edge
	assign wrBus.loWrite = !low_byte_write_strobe_n;
	assign wrBus.hiWrite = !high_byte_write_strobe_n;
	assign wrBus.addr    = addrReg;
	assign wrBus.data    = dataLatch;

	sram_array u_array (
		.clk_sys  (clk_sys),
		.readAddr (addr),
		.readData (arrayData),
		.wr       (wrBus)
	);

	// read word is registered, so it stays put for a whole cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dataOut <= cache_sram_pkg::DATA_RESET;
		end else begin
			dataOut <= arrayData;
		end
	end

	// drivers follow the output enable; strobes alone never release the pins, hence upstream
	assign next_driveOff = outputDrive_n;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dataOutEnable_n <= 1'b1;
		end else begin
			dataOutEnable_n <= next_driveOff;
		end
	end

	chk_addr_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
		addrReg == $past(addr, 1) || $past(!rst_n, 1))
		else $error("address register missed the rising edge");
	chk_read_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		low_byte_write_strobe_n && high_byte_write_strobe_n ##1 $stable(addr)
		&& low_byte_write_strobe_n && high_byte_write_strobe_n |-> ##2 $stable(dataOut))
		else $error("read data changed without address change");
	chk_drive_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!outputDrive_n |=> !dataOutEnable_n)
		else $error("drivers not enabled after enable low");
	chk_drive_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		outputDrive_n |=> dataOutEnable_n)
		else $error("drivers not released after enable high");
	chk_write_low: assert property (@(negedge clk_sys) disable iff (!rst_n)
		!low_byte_write_strobe_n |-> wrBus.loWrite && wrBus.addr == addrReg)
		else $error("low byte write not launched");
	chk_write_high: assert property (@(negedge clk_sys) disable iff (!rst_n)
		!high_byte_write_strobe_n |-> wrBus.hiWrite && wrBus.data == dataLatch)
		else $error("high byte write not launched");
	chk_no_write: assert property (@(negedge clk_sys) disable iff (!rst_n)
		low_byte_write_strobe_n && high_byte_write_strobe_n |-> !wrBus.loWrite && !wrBus.hiWrite)
		else $error("write without strobe");
	chk_data_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> dataLatch == $past(dataIn, 1))
		else $error("data-in latch stale");
endmodule // sync_cache_sram

// [bench/ctrl_model.sv]
/* controller model: turns simple bench requests into memory pin levels.
   assumes the bench changes its requests on the falling clock edge. */
`timescale 1ns/10ps
module ctrl_model (
	input  wire logic [1:0]  op,
	input  wire logic [13:0] reqAddr,
	input  wire logic [15:0] reqData,
	input  wire logic [1:0]  mask,
	output logic      [13:0] addr,
	output logic             loStrobe_n,
	output logic             hiStrobe_n,
	output logic             outputDrive_n,
	output logic      [15:0] dataIn
);
	// op 1 writes, op 2 reads; drivers stay off for the whole write
	assign outputDrive_n = (op != 2'h2);
	assign loStrobe_n    = !(op == 2'h1 && mask[0]);
	assign hiStrobe_n    = !(op == 2'h1 && mask[1]);
	assign addr          = reqAddr;
	// outside writes the pins show no stale word
	assign dataIn        = (op == 2'h1) ? reqData : ~reqData;
endmodule // ctrl_model

// [bench/testbench.sv]
/* self-checking bench for the cache memory, reset values first, then rows, then edge cases.
   assumes the controller model sits between bench and memory pins. */
`timescale 1ns/10ps
module testbench;
	typedef struct {logic [1:0] op; logic [13:0] a; logic [15:0] d; logic [1:0] m;} row_t;
	logic        clk_sys, rst_n, loStrobe_n, hiStrobe_n, outputDrive_n, dataOutEnable_n;
	logic [1:0]  op, mask;
	logic [13:0] reqAddr, addr;
	logic [15:0] reqData, dataIn, dataOut;
	int          miscompares = 0, n_tests = 0, cycles = 0;
	// reads carry the expected word in d
	row_t rows [9] = '{'{1, 14'h0000, 16'h1234, 3}, '{1, 14'h3FFF, 16'hABCD, 3}, '{2, 14'h0000, 16'h1234, 0},
		'{2, 14'h3FFF, 16'hABCD, 0}, '{1, 14'h0000, 16'hFF00, 1}, '{1, 14'h0000, 16'h5677, 2},
		'{2, 14'h0000, 16'h5600, 0}, '{1, 14'h3FFF, 16'h0000, 0}, '{2, 14'h3FFF, 16'hABCD, 0}};
	ctrl_model i_ctrl (.op(op), .reqAddr(reqAddr), .reqData(reqData), .mask(mask), .addr(addr),
		.loStrobe_n(loStrobe_n), .hiStrobe_n(hiStrobe_n), .outputDrive_n(outputDrive_n), .dataIn(dataIn));
	sync_cache_sram i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .low_byte_write_strobe_n(loStrobe_n),
		.high_byte_write_strobe_n(hiStrobe_n), .outputDrive_n(outputDrive_n), .dataIn(dataIn),
		.dataOut(dataOut), .dataOutEnable_n(dataOutEnable_n));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// hang guard: the whole run needs well under a hundred cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 500) begin
			miscompares++;
			give_verdict();
		end
	end
	initial begin
		rst_n = 1'b0; op = 2'h0; mask = 2'h0; reqAddr = 14'h0000; reqData = 16'h0000;
		repeat (2) @(negedge clk_sys);
		check(dataOut, 16'h0000);
		check({15'h0000, dataOutEnable_n}, 16'h0001);
		rst_n <= 1'b1;
		// one request, an idle cycle, then the read word two edges on
		foreach (rows[i]) begin
			@(negedge clk_sys);
			op <= rows[i].op; reqAddr <= rows[i].a; reqData <= rows[i].d; mask <= rows[i].m;
			@(negedge clk_sys);
			op <= 2'h0;
			if (rows[i].op == 2'h2) check({15'h0000, dataOutEnable_n}, 16'h0000);
			@(negedge clk_sys);
			if (rows[i].op == 2'h2) check(dataOut, rows[i].d);
		end
		// back-to-back reads at both ends of the address range
		op <= 2'h2; reqAddr <= 14'h0000;
		@(negedge clk_sys);
		reqAddr <= 14'h3FFF;
		@(negedge clk_sys);
		op <= 2'h0;
		check(dataOut, 16'h5600);
		@(negedge clk_sys);
		check(dataOut, 16'hABCD);
		give_verdict();
	end
endmodule // testbench
